// >>> core/aux_count_source_gen.sv
// auxiliary count source generator: two cascaded down-count dividers
// assumes register port and consumers sit on mclk_i; ticks are clock enables
//
// Strobed register access and the register offsets were decided locally.
`timescale 1ns/100ps

module aux_count_source_gen
(
	// clock and reset
	input wire logic mclk_i,
	input wire logic resetn_i,
	// register port
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	// generated clock and consumer enables
	output logic derived_count_clock_o,
	output logic timer_x_tick_o,
	output logic serial_tick_o,
	output logic uart1_tick_o,
	output logic uart2_tick_o
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [7:0] gating_latch_ff;
	logic [7:0] gating_count_ff;
	logic [7:0] final_latch_ff;
	logic [7:0] final_count_ff;
	logic [2:0] mode_ff;
	logic [3:0] sel_ff;
	logic gating_running;
	logic final_source;
	logic final_underflow;
	logic wr_gating;
	logic wr_final;

	assign wr_gating = reg_wr_i && (reg_addr_i == aux_count_source_pkg::GATING_TIMER_IDX);
	assign wr_final = reg_wr_i && (reg_addr_i == aux_count_source_pkg::FINAL_DIVIDE_TIMER_IDX);

	// ----------------------------------------------------------------
	// gating
	// ----------------------------------------------------------------
	// a zero setting would gate every edge, so it counts as stopped
	assign gating_running = !mode_ff[aux_count_source_pkg::HALT_BIT_POS]
		&& (gating_latch_ff != 8'h00);
	// the underflow cycle of the gating timer removes one source edge
	assign final_source = gating_running ? (gating_count_ff != 8'h00) : 1'b1;
	assign final_underflow = final_source && (final_count_ff == 8'h00);

	// ----------------------------------------------------------------
	// configuration registers
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			mode_ff <= aux_count_source_pkg::MODE_RESET;
			sel_ff <= aux_count_source_pkg::CONSUMER_SEL_RESET;
		end
		else if (reg_wr_i)
		begin
			if (reg_addr_i == aux_count_source_pkg::MODE_IDX)
				mode_ff <= reg_wdata_i[2:0];
			if (reg_addr_i == aux_count_source_pkg::CONSUMER_SEL_IDX)
				sel_ff <= reg_wdata_i[3:0];
		end
	end

	// ----------------------------------------------------------------
	// gating timer
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			gating_latch_ff <= aux_count_source_pkg::TIMER_RESET;
			gating_count_ff <= aux_count_source_pkg::TIMER_RESET;
		end
		else
		begin
			if (wr_gating)
				gating_latch_ff <= reg_wdata_i;
			if (wr_gating && !mode_ff[aux_count_source_pkg::GATING_WCTL_POS])
				gating_count_ff <= reg_wdata_i;
			else if (gating_running)
			begin
				if (gating_count_ff == 8'h00)
					gating_count_ff <= gating_latch_ff;
				else
					gating_count_ff <= gating_count_ff - 8'h01;
			end
		end
	end

	// ----------------------------------------------------------------
	// final divide timer
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			final_latch_ff <= aux_count_source_pkg::TIMER_RESET;
			final_count_ff <= aux_count_source_pkg::TIMER_RESET;
		end
		else
		begin
			if (wr_final)
				final_latch_ff <= reg_wdata_i;
			if (wr_final && !mode_ff[aux_count_source_pkg::FINAL_WCTL_POS])
				final_count_ff <= reg_wdata_i;
			else if (final_source)
			begin
				if (final_count_ff == 8'h00)
					final_count_ff <= final_latch_ff;
				else
					final_count_ff <= final_count_ff - 8'h01;
			end
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	// registered for clean enables; costs one cycle of latency
	always_ff @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			derived_count_clock_o <= 1'b0;
			timer_x_tick_o <= 1'b0;
			serial_tick_o <= 1'b0;
			uart1_tick_o <= 1'b0;
			uart2_tick_o <= 1'b0;
		end
		else
		begin
			derived_count_clock_o <= final_underflow;
			timer_x_tick_o <= sel_ff[aux_count_source_pkg::SEL_TIMER_X_POS] ? final_underflow : 1'b1;
			serial_tick_o <= sel_ff[aux_count_source_pkg::SEL_SERIAL_POS] ? final_underflow : 1'b1;
			uart1_tick_o <= sel_ff[aux_count_source_pkg::SEL_UART1_POS] ? final_underflow : 1'b1;
			uart2_tick_o <= sel_ff[aux_count_source_pkg::SEL_UART2_POS] ? final_underflow : 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// read port
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			reg_rdata_o <= 8'h00;
		else if (reg_rd_i)
		begin
			case (reg_addr_i)
				aux_count_source_pkg::GATING_TIMER_IDX: reg_rdata_o <= gating_latch_ff;
				aux_count_source_pkg::FINAL_DIVIDE_TIMER_IDX: reg_rdata_o <= final_latch_ff;
				aux_count_source_pkg::MODE_IDX: reg_rdata_o <= {5'h00, mode_ff};
				aux_count_source_pkg::CONSUMER_SEL_IDX: reg_rdata_o <= {4'h0, sel_ff};
				aux_count_source_pkg::GATING_COUNT_IDX: reg_rdata_o <= gating_count_ff;
				aux_count_source_pkg::FINAL_COUNT_IDX: reg_rdata_o <= final_count_ff;
				default: reg_rdata_o <= 8'h00;
			endcase
		end
		else
			reg_rdata_o <= 8'h00;
	end

endmodule : aux_count_source_gen

// >>> core/aux_count_source_pkg.sv
// constants for the auxiliary count source generator
// assumes an 8-bit register port driven from the same clock as the block
package aux_count_source_pkg;

	// ----------------------------------------------------------------
	// register indices
	// ----------------------------------------------------------------
	localparam logic [7:0] GATING_TIMER_IDX = 8'h00;
	localparam logic [7:0] FINAL_DIVIDE_TIMER_IDX = 8'h01;
	localparam logic [7:0] MODE_IDX = 8'h02;
	localparam logic [7:0] CONSUMER_SEL_IDX = 8'h03;
	localparam logic [7:0] GATING_COUNT_IDX = 8'h04;
	localparam logic [7:0] FINAL_COUNT_IDX = 8'h05;

	// ----------------------------------------------------------------
	// mode register fields
	// ----------------------------------------------------------------
	localparam int HALT_BIT_POS = 0;
	localparam int GATING_WCTL_POS = 1;
	localparam int FINAL_WCTL_POS = 2;

	// ----------------------------------------------------------------
	// consumer select fields
	// ----------------------------------------------------------------
	localparam int SEL_TIMER_X_POS = 0;
	localparam int SEL_SERIAL_POS = 1;
	localparam int SEL_UART1_POS = 2;
	localparam int SEL_UART2_POS = 3;

	// ----------------------------------------------------------------
	// values after reset
	// ----------------------------------------------------------------
	localparam logic [7:0] TIMER_RESET = 8'hFF;
	localparam logic [2:0] MODE_RESET = 3'h0;
	localparam logic [3:0] CONSUMER_SEL_RESET = 4'h0;

endpackage : aux_count_source_pkg

// >>> testbench/aux_count_source_assertions.sv
// port checker for the count source generator
// assumes it is bound to the generator and sees only its ports
`timescale 1ns/100ps
module aux_count_source_chk
(
	input wire logic mclk_i, resetn_i, reg_wr_i, reg_rd_i,
	input wire logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o,
	input wire logic derived_count_clock_o, timer_x_tick_o, serial_tick_o, uart1_tick_o, uart2_tick_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!resetn_i);
	property p_idle; !reg_rd_i |=> !reg_rdata_o; endproperty
	a_idle: assert property (p_idle) else $error("stray read data");
	property p_unmap; reg_rd_i && reg_addr_i > 8'h05 |=> !reg_rdata_o; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read");
	property p_latch; reg_wr_i && reg_addr_i < 8'h02 ##1 !reg_wr_i
		##1 reg_rd_i && reg_addr_i == $past(reg_addr_i, 2) |=> reg_rdata_o == $past(reg_wdata_i, 3); endproperty
	a_latch: assert property (p_latch) else $error("latch readback");
	property p_mode; reg_wr_i && reg_addr_i == 8'h02 ##1 !reg_wr_i
		##1 reg_rd_i && reg_addr_i == 8'h02 |=> reg_rdata_o == ($past(reg_wdata_i, 3) & 8'h07); endproperty
	a_mode: assert property (p_mode) else $error("mode readback");
	property p_tx; derived_count_clock_o |-> timer_x_tick_o; endproperty
	a_tx: assert property (p_tx) else $error("timer x tick");
	property p_ser; derived_count_clock_o |-> serial_tick_o; endproperty
	a_ser: assert property (p_ser) else $error("serial tick");
	property p_u1; derived_count_clock_o |-> uart1_tick_o; endproperty
	a_u1: assert property (p_u1) else $error("uart1 tick");
	property p_u2; derived_count_clock_o |-> uart2_tick_o; endproperty
	a_u2: assert property (p_u2) else $error("uart2 tick");
	c_pulse: cover property (derived_count_clock_o);
	c_gap: cover property (!timer_x_tick_o);
	c_count: cover property (reg_rd_i && reg_addr_i == 8'h05);
endmodule : aux_count_source_chk
bind aux_count_source_gen aux_count_source_chk chk (.*);

// >>> testbench/test_aux_count_source_gen.sv
// bench: table of register calls and divider period checks
// assumes the bound checker and one consumer on the generated clock
`timescale 1ns/100ps
module test_aux_count_source_gen;
	logic mclk_i = 1'b0, resetn_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0, dclk;
	logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o, d, op, a, v;
	logic [3:0] ticks, sel = 4'h5;
	logic [15:0] cnt, c0;
	int errors = 0, n_tests = 0, n;
	// op, index, value: 0 write, 1 read equal, 2 period, 3 count below, 4 count above
	logic [23:0] prog [24] = '{24'h0100FF, 24'h010900,
		24'h000305, 24'h0002F9, 24'h010201, 24'h000102, 24'h020003,
		24'h000100, 24'h020001,
		24'h000200, 24'h000001, 24'h010001, 24'h000101, 24'h020004,
		24'h000000, 24'h000110, 24'h020011,
		24'h000205, 24'h0001C8, 24'h030511, 24'h0200C9,
		24'h000201, 24'h0001C8, 24'h0405C4};
	always #2 mclk_i = ~mclk_i;
	aux_count_source_gen dut (.*, .derived_count_clock_o(dclk), .timer_x_tick_o(ticks[0]),
		.serial_tick_o(ticks[1]), .uart1_tick_o(ticks[2]), .uart2_tick_o(ticks[3]));
	tick_consumer_model consumer (.mclk_i, .resetn_i, .tick_i(dclk), .count_o(cnt));
	// idle edge after each access keeps strobes from being reassigned in one step
	task automatic acc(input logic w, input logic [7:0] ad, input logic [7:0] wd);
		{reg_addr_i, reg_wdata_i, reg_wr_i, reg_rd_i} <= {ad, wd, w, !w};
		@(posedge mclk_i);
		{reg_wr_i, reg_rd_i} <= 2'b00;
		// read data stand only in this cycle; sample once settled
		#1 d = reg_rdata_o;
		@(posedge mclk_i);
	endtask : acc
	// first pass syncs to a pulse, second counts clocks to the next one
	task automatic period(input logic [7:0] exp);
		repeat (2)
		begin
			c0 = cnt;
			for (n = 0; cnt === c0 && n < 700; n++)
				@(posedge mclk_i);
		end
		@(posedge mclk_i);
		d = (exp < 8'h03 || ticks === ~sel) ? n[7:0] : 8'h00;
	endtask : period
	task give_verdict;
		if (errors == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : give_verdict
	initial
	begin
		repeat (8)
			@(posedge mclk_i);
		resetn_i <= 1'b1;
		foreach (prog[i])
		begin
			{op, a, v} = prog[i];
			if (op == 8'h02)
				period(v);
			else
				acc(op == 8'h00, a, v);
			n_tests++;
			if ((op == 8'h03 ? d < v : op == 8'h04 ? d > v : d === (op == 8'h00 ? 8'h00 : v)) !== 1'b1)
			begin
				errors++;
				$display("wrong value at %0t: step %0d", $time, i);
			end
		end
		give_verdict;
	end
	initial
	begin
		#20000 errors++;
		give_verdict;
	end
endmodule : test_aux_count_source_gen

// >>> testbench/tick_consumer_model.sv
// consumer model: counts the enable pulses it is handed
// assumes ticks are one-cycle enables on mclk_i
`timescale 1ns/100ps
module tick_consumer_model
(
	input wire logic mclk_i, resetn_i, tick_i,
	output logic [15:0] count_o
);
	always_ff @(posedge mclk_i or negedge resetn_i)
		count_o <= !resetn_i ? 16'h0000 : count_o + 16'(tick_i);
endmodule : tick_consumer_model
